// >>> tofr_pkg.sv
// Purpose: Constants for the time-of-flight result register slice.
// Assumes: 16-bit result words, 8-bit register addresses.
// Notes: Time values are in periods of the 4 MHz reference.
package tofr_pkg;
  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [7:0] ADDR_UP_AVG_FRAC = 8'hD2;
  localparam logic [7:0] ADDR_DN_WAVE_RATIO = 8'hD3;
  localparam logic [7:0] ADDR_DN_HIT1_INT = 8'hD4;
  localparam logic [7:0] ADDR_DN_HIT1_FRAC = 8'hD5;
  localparam logic [7:0] ADDR_DN_HIT2_INT = 8'hD6;
  localparam logic [7:0] ADDR_DN_HIT2_FRAC = 8'hD7;
  localparam logic [7:0] ADDR_DN_HIT3_INT = 8'hD8;
  // ****************************************
  // Field layout and values
  // ****************************************
  localparam int INT_WIDTH = 15;
  localparam int FRAC_WIDTH = 16;
  localparam int RATIO_WIDTH = 8;
  localparam int RATIO_FRAC_BITS = 7;
  localparam int RATIO_HI_LSB = 8;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [14:0] INT_MAX = 15'h7FFF;
  localparam logic [15:0] FRAC_MAX = 16'hFFFF;
  localparam logic [7:0] RATIO_MAX = 8'hFF;
  localparam logic [15:0] UNMAPPED_READ = 16'h0000;
endpackage : tofr_pkg

// >>> tofr_load_if.sv
// Purpose: Carries measurement results from the engine side into the bank.
// Assumes: One clock domain.
// Notes: load is a one-cycle strobe with all fields valid.
`timescale 1ns/100ps
interface tofr_load_if;
  logic load;
  logic [14:0] up_avg_int;
  logic [15:0] up_avg_frac;
  logic [15:0] ratio_t1_t2;
  logic [15:0] ratio_t2_ideal;
  logic [14:0] dn_int [0:2];
  logic [15:0] dn_frac [0:1];
  modport source (output load, up_avg_int, up_avg_frac, ratio_t1_t2, ratio_t2_ideal, dn_int, dn_frac);
  modport sink (input load, up_avg_int, up_avg_frac, ratio_t1_t2, ratio_t2_ideal, dn_int, dn_frac);
endinterface : tofr_load_if

// >>> tofr_ratio_sat.sv
// Purpose: Clamps a 1.7 fixed-point ratio to its all-ones code.
// Assumes: Input is an unsigned 1.15 fixed-point ratio.
// Notes: Larger ratios than just under two report 8'hFF.
`timescale 1ns/100ps
module tofr_ratio_sat
  import tofr_pkg::*;
(
  // Raw ratio, 1 integer bit and 15 fraction bits over a wider range
  input wire logic [15:0] raw,
  input wire logic overflow,
  // Clamped byte
  output logic [7:0] ratio
);
  wire logic [7:0] truncated;
  // Keep the top integer bit and seven fraction bits
  assign truncated = raw[15:8];
  assign ratio = overflow ? RATIO_MAX : truncated;
endmodule : tofr_ratio_sat

// >>> tofr_result_bank.sv
// Purpose: Read-only result registers D2h..D8h of the time-of-flight engine.
// Assumes: Synchronous reads, results loaded by a one-cycle strobe.
// Notes: Reads return data one cycle after the request.
// Summary of operation
// - Upstream average fraction as read-only 16-bit word
// - Fraction LSB is reference period over 65536
// - Fraction spans zero to all ones
// - Ratio high byte is first over second width
// - Ratio low byte is second over ideal width
// - Ratio bytes are 1.7 unsigned fixed point
// - Downstream hit integer is 15-bit period count
// - Downstream hit fraction pairs with its integer
// - Upstream average integer is 15-bit count
`timescale 1ns/100ps
module tofr_result_bank
  import tofr_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Results from the measurement engine
  input wire logic load,
  input wire logic [14:0] up_avg_int,
  input wire logic [15:0] up_avg_frac,
  input wire logic [15:0] raw_t1_t2,
  input wire logic ovf_t1_t2,
  input wire logic [15:0] raw_t2_ideal,
  input wire logic ovf_t2_ideal,
  input wire logic [14:0] dn_hit1_int,
  input wire logic [15:0] dn_hit1_frac,
  input wire logic [14:0] dn_hit2_int,
  input wire logic [15:0] dn_hit2_frac,
  input wire logic [14:0] dn_hit3_int,
  // Register read port
  input wire logic rd_en,
  input wire logic [7:0] rd_addr,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic rd_hit,
  // Upstream average integer, paired with the fraction word
  output logic [15:0] upstream_average_integer
);
  tofr_load_if ld ();
  wire logic [7:0] ratio_hi;
  wire logic [7:0] ratio_lo;

  // ****************************************
  // Ratio clamping
  // ****************************************
  tofr_ratio_sat sat_hi (
    .raw(raw_t1_t2),
    .overflow(ovf_t1_t2),
    .ratio(ratio_hi)
  );
  tofr_ratio_sat sat_lo (
    .raw(raw_t2_ideal),
    .overflow(ovf_t2_ideal),
    .ratio(ratio_lo)
  );

  assign ld.load = load;
  assign ld.up_avg_int = up_avg_int;
  assign ld.up_avg_frac = up_avg_frac;
  assign ld.ratio_t1_t2 = {ratio_hi, 8'h00};
  assign ld.ratio_t2_ideal = {8'h00, ratio_lo};
  assign ld.dn_int[0] = dn_hit1_int;
  assign ld.dn_int[1] = dn_hit2_int;
  assign ld.dn_int[2] = dn_hit3_int;
  assign ld.dn_frac[0] = dn_hit1_frac;
  assign ld.dn_frac[1] = dn_hit2_frac;

  // ****************************************
  // Result storage
  // ****************************************
  logic [15:0] upstream_average_fraction;
  logic [15:0] downstream_wave_ratio;
  logic [14:0] downstream_first_hit_integer;
  logic [15:0] downstream_first_hit_fraction;
  logic [14:0] downstream_second_hit_integer;
  logic [15:0] downstream_second_hit_fraction;
  logic [14:0] downstream_third_hit_integer;
  logic [14:0] up_int_q;
  wire logic [15:0] next_wave_ratio;

  // Each ratio byte is zero in the other half of its source word, so an OR merges them
  assign next_wave_ratio = ld.ratio_t1_t2 | ld.ratio_t2_ideal;

  // Every word shares the one load strobe, so a read never mixes two measurements
  always_ff @(posedge clock) begin
    if (!nrst) begin
      upstream_average_fraction <= WORD_RESET;
    end else if (ld.load) begin
      upstream_average_fraction <= ld.up_avg_frac;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      downstream_wave_ratio <= WORD_RESET;
    end else if (ld.load) begin
      downstream_wave_ratio <= next_wave_ratio;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      downstream_first_hit_integer <= WORD_RESET[14:0];
    end else if (ld.load) begin
      downstream_first_hit_integer <= ld.dn_int[0];
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      downstream_first_hit_fraction <= WORD_RESET;
    end else if (ld.load) begin
      downstream_first_hit_fraction <= ld.dn_frac[0];
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      downstream_second_hit_integer <= WORD_RESET[14:0];
    end else if (ld.load) begin
      downstream_second_hit_integer <= ld.dn_int[1];
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      downstream_second_hit_fraction <= WORD_RESET;
    end else if (ld.load) begin
      downstream_second_hit_fraction <= ld.dn_frac[1];
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      downstream_third_hit_integer <= WORD_RESET[14:0];
    end else if (ld.load) begin
      downstream_third_hit_integer <= ld.dn_int[2];
    end
  end

  // No address in this slice; the word leaves through its own port instead
  always_ff @(posedge clock) begin
    if (!nrst) begin
      up_int_q <= WORD_RESET[14:0];
    end else if (ld.load) begin
      up_int_q <= ld.up_avg_int;
    end
  end

  // ****************************************
  // Read decode
  // ****************************************
  wire logic sel_uaf;
  wire logic sel_wvr;
  wire logic sel_h1i;
  wire logic sel_h1f;
  wire logic sel_h2i;
  wire logic sel_h2f;
  wire logic sel_h3i;
  wire logic any_sel;
  wire logic [15:0] read_mux;

  assign sel_uaf = (rd_addr == ADDR_UP_AVG_FRAC);
  assign sel_wvr = (rd_addr == ADDR_DN_WAVE_RATIO);
  assign sel_h1i = (rd_addr == ADDR_DN_HIT1_INT);
  assign sel_h1f = (rd_addr == ADDR_DN_HIT1_FRAC);
  assign sel_h2i = (rd_addr == ADDR_DN_HIT2_INT);
  assign sel_h2f = (rd_addr == ADDR_DN_HIT2_FRAC);
  assign sel_h3i = (rd_addr == ADDR_DN_HIT3_INT);
  assign any_sel = sel_uaf | sel_wvr | sel_h1i | sel_h1f | sel_h2i | sel_h2f | sel_h3i;
  // Integer words read with bit 15 as zero
  assign read_mux = sel_uaf ? upstream_average_fraction :
                    sel_wvr ? downstream_wave_ratio :
                    sel_h1i ? {1'b0, downstream_first_hit_integer} :
                    sel_h1f ? downstream_first_hit_fraction :
                    sel_h2i ? {1'b0, downstream_second_hit_integer} :
                    sel_h2f ? downstream_second_hit_fraction :
                    sel_h3i ? {1'b0, downstream_third_hit_integer} :
                    UNMAPPED_READ;

  // ****************************************
  // Read port outputs
  // ****************************************
  wire logic [15:0] next_rd_data;
  wire logic next_rd_hit;
  wire logic [15:0] next_up_avg_int;

  // Idle cycles return zero so a stale word is never taken for an answer
  assign next_rd_data = rd_en ? read_mux : WORD_RESET;
  assign next_rd_hit = rd_en & any_sel;
  assign next_up_avg_int = {1'b0, up_int_q};

  always_ff @(posedge clock) begin
    if (!nrst) begin
      rd_data <= WORD_RESET;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      rd_hit <= 1'b0;
    end else begin
      rd_hit <= next_rd_hit;
    end
  end

  // Costs one cycle behind the stored word, but keeps the port straight off a flop
  always_ff @(posedge clock) begin
    if (!nrst) begin
      upstream_average_integer <= WORD_RESET;
    end else begin
      upstream_average_integer <= next_up_avg_int;
    end
  end
endmodule : tofr_result_bank

// >>> tofr_result_bank_checker.sv
// Purpose: Port timing checks on the result bank read port and average integer port.
// Assumes: One clock, synchronous active-low reset.
// Notes: Watches top-level ports only.
`timescale 1ns/100ps
module tofr_result_bank_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Watched ports
  input wire logic load,
  input wire logic [14:0] up_avg_int,
  input wire logic rd_en,
  input wire logic [7:0] rd_addr,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  input wire logic rd_hit,
  input wire logic [15:0] upstream_average_integer
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  wire mapped = rd_addr >= 8'hD2 && rd_addr <= 8'hD8;
  property p_valid; rd_en |=> rd_valid; endproperty
  a_valid: assert property (p_valid) else $error("read not answered");
  property p_idle; !rd_en |=> !rd_valid && rd_data == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("data without read");
  property p_hit; rd_en |=> rd_hit == $past(mapped); endproperty
  a_hit: assert property (p_hit) else $error("hit flag wrong");
  property p_unmap; rd_en && !mapped |=> rd_data == 16'h0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_int; rd_en && rd_addr inside {8'hD4, 8'hD6, 8'hD8} |=> !rd_data[15]; endproperty
  a_int: assert property (p_int) else $error("integer word top bit set");
  property p_upint; load |-> ##2 upstream_average_integer == {1'b0, $past(up_avg_int, 2)}; endproperty
  a_upint: assert property (p_upint) else $error("average integer not loaded");
  property p_msb; !upstream_average_integer[15]; endproperty
  a_msb: assert property (p_msb) else $error("average integer top bit set");
  // Read-only: a repeated read with no load between must not change
  property p_hold; (rd_en && rd_addr == 8'hD2) ##1 (rd_en && rd_addr == 8'hD2 && !$past(load)) |=> $stable(rd_data); endproperty
  a_hold: assert property (p_hold) else $error("read changed stored word");
  property p_hitv; rd_hit |-> rd_valid; endproperty
  a_hitv: assert property (p_hitv) else $error("hit flag without valid");
endmodule : tofr_result_bank_checker

// >>> test_tofr_result_bank.sv
// Purpose: Self-checking bench for the result register bank.
// Assumes: Reads answer one cycle after rd_en.
// Notes: Model keeps expected words by address; unmapped stay zero.
`timescale 1ns/100ps
module test_tofr_result_bank import tofr_pkg::*; ;
  logic clock = 0, nrst = 0, load = 0, ovf_t1_t2 = 0, ovf_t2_ideal = 0, rd_en = 0;
  logic [14:0] up_avg_int = 0, dn_hit1_int = 0, dn_hit2_int = 0, dn_hit3_int = 0;
  logic [15:0] up_avg_frac = 0, raw_t1_t2 = 0, raw_t2_ideal = 0, dn_hit1_frac = 0, dn_hit2_frac = 0;
  logic [7:0] rd_addr = 0;
  logic [15:0] rd_data, upstream_average_integer, exp_up;
  logic rd_valid, rd_hit;
  logic [15:0] model [0:255];
  int mismatches = 0, check_count = 0;
  // Repeated D2 and out-of-range neighbours are the awkward cases
  logic [7:0] q [$] = '{8'hD2, 8'hD2, 8'hD3, 8'hD4, 8'hD5, 8'hD6, 8'hD7, 8'hD8, 8'hD1, 8'hD9, 8'hFF};
  tofr_result_bank i_tofr_result_bank (.clock, .nrst, .load, .up_avg_int, .up_avg_frac, .raw_t1_t2, .ovf_t1_t2,
    .raw_t2_ideal, .ovf_t2_ideal, .dn_hit1_int, .dn_hit1_frac, .dn_hit2_int, .dn_hit2_frac, .dn_hit3_int,
    .rd_en, .rd_addr, .rd_data, .rd_valid, .rd_hit, .upstream_average_integer);
  // ****************************
  // Checking and stimulus tasks
  // ****************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_flags(input logic valid, input logic hit, input logic exp_hit);
    chk({14'h0000, valid, hit}, {14'h0000, 1'b1, exp_hit});
  endtask : chk_flags
  task automatic chk_avg(input logic [15:0] got, input logic [15:0] exp);
    chk(got, exp);
  endtask : chk_avg
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  task automatic load_set(input bit mx);
    @(posedge clock);
    load <= 1'b1;
    {up_avg_int, up_avg_frac, raw_t1_t2, raw_t2_ideal} <= mx ? '1 : 63'({$urandom, $urandom});
    {dn_hit1_int, dn_hit1_frac, dn_hit2_int, dn_hit2_frac, dn_hit3_int} <= mx ? '1 : 77'({$urandom, $urandom, $urandom});
    {ovf_t1_t2, ovf_t2_ideal} <= mx ? 2'h0 : 2'($urandom);
    @(posedge clock);
    load <= 1'b0;
    model[8'hD2] = up_avg_frac;
    model[8'hD3] = {ovf_t1_t2 ? 8'hFF : raw_t1_t2[15:8], ovf_t2_ideal ? 8'hFF : raw_t2_ideal[15:8]};
    model[8'hD4] = {1'b0, dn_hit1_int};
    model[8'hD5] = dn_hit1_frac;
    model[8'hD6] = {1'b0, dn_hit2_int};
    model[8'hD7] = dn_hit2_frac;
    model[8'hD8] = {1'b0, dn_hit3_int};
    exp_up = {1'b0, up_avg_int};
  endtask : load_set
  // Reads go back to back; each answer is checked one edge later
  task automatic sweep;
    for (int i = 0; i <= q.size(); i++) begin
      @(posedge clock);
      rd_en <= i < q.size();
      if (i < q.size()) rd_addr <= q[i];
      #1;
      if (i > 0) begin
        chk(rd_data, model[q[i-1]]);
        chk_flags(rd_valid, rd_hit, q[i-1] >= 8'hD2 && q[i-1] <= 8'hD8);
      end
    end
    chk_avg(upstream_average_integer, exp_up);
  endtask : sweep
  initial begin
    forever #12.5 clock = ~clock;
  end
  initial begin
    foreach (model[a]) model[a] = 16'h0000;
    exp_up = 16'h0000;
    void'($urandom(18337));
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    sweep();
    load_set(1'b1);
    sweep();
    repeat (8) begin
      load_set(1'b0);
      sweep();
    end
    // A reset in mid-run must clear every stored word and the exported integer
    @(posedge clock);
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    foreach (model[a]) model[a] = 16'h0000;
    exp_up = 16'h0000;
    sweep();
    load_set(1'b0);
    sweep();
    test_done();
  end
endmodule : test_tofr_result_bank
bind tofr_result_bank tofr_result_bank_checker i_tofr_result_bank_checker (.clock, .nrst, .load, .up_avg_int,
  .rd_en, .rd_addr, .rd_data, .rd_valid, .rd_hit, .upstream_average_integer);
